// *** logic/psr_pkg.sv ***
// Constants for the pipelined burst static memory block.
// Assumes one clock domain; master logic drives pins synchronously.
//
// Overview of operation
// - Address, selects, write controls and data are sampled on rising edges.
// - Read data leaves through an output register, never from the array.
// - With the clock qualifier inactive, every register except the two-stage sleep synchroniser and the array, which still commits a pending write, holds its value.
// - Writes update only the byte lanes whose write select is active.
// - A load cycle acts only when all three chip selects are active; an advance repeats the last load's select result.
// - Output enable tri-states the data drivers at once, without the clock.
// - Drivers are off during the cycle in which write data is taken.
// - Reads and writes may follow each other on every cycle, any mix.
// - Burst addresses step in linear or interleaved order by a setting.
// - Array writes complete internally; no write pulse needed from outside.
// - A sleep input quiets the block; a stopped clock loses no state.
// - Storage is words by lanes sized for the organisation, address to match.
package psr_pkg;

    // ==========================================================
    // Organisation: 2M words of 36 bits, four 9-bit lanes
    localparam int ADDR_W  = 21;
    localparam int DATA_W  = 36;
    localparam int LANE_N  = 4;
    localparam int LANE_W  = 9;
    localparam int BURST_W = 2;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0]  RST_DATA  = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0]  RST_ADDR  = 21'h00_0000;
    localparam logic [LANE_N-1:0]  RST_SEL   = 4'h0;
    localparam logic [BURST_W-1:0] RST_BURST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

endpackage

// *** logic/psr_array.sv ***
// Storage array with per-lane writes and a combinational read port.
// Assumes the caller presents write requests one clock after capture.
`timescale 1ns/10ps

module psr_array (
    input  wire logic                           core_clk,
    input  wire logic                           wr_en,
    input  wire logic [psr_pkg::ADDR_W-1:0]     wr_addr,
    input  wire logic [psr_pkg::DATA_W-1:0]     wr_data,
    input  wire logic [psr_pkg::LANE_N-1:0]     wr_sel,
    input  wire logic [psr_pkg::ADDR_W-1:0]     rd_addr,
    output logic      [psr_pkg::DATA_W-1:0]     rd_data
);

    // ==========================================================
    // Array
    logic [psr_pkg::DATA_W-1:0] mem [0:(1 << psr_pkg::ADDR_W)-1];
    logic [psr_pkg::DATA_W-1:0] old_word;
    logic [psr_pkg::DATA_W-1:0] new_word;

    assign old_word = mem[wr_addr];
    assign rd_data  = mem[rd_addr];

    genvar g;
    generate
        for (g = 0; g < psr_pkg::LANE_N; g++) begin : g_lane
            assign new_word[g*psr_pkg::LANE_W +: psr_pkg::LANE_W] =
                wr_sel[g] ? wr_data[g*psr_pkg::LANE_W +: psr_pkg::LANE_W]
                          : old_word[g*psr_pkg::LANE_W +: psr_pkg::LANE_W];
        end
    endgenerate

    // Self-timed commit: one edge, no pulse shaping from outside
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= new_word;
        end
    end

endmodule // psr_array

// *** logic/psr_burst.sv ***
// Burst address generator: loads a base or steps a 2-bit counter.
// Assumes step is high only on enabled clock edges.
`timescale 1ns/10ps

module psr_burst (
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    input  wire logic                         step,
    input  wire logic                         load,
    input  wire logic                         burst_linear,
    input  wire logic [psr_pkg::ADDR_W-1:0]   addr_in,
    output logic      [psr_pkg::ADDR_W-1:0]   addr_out
);

    logic [psr_pkg::ADDR_W-1:0]  base_r;
    logic [psr_pkg::ADDR_W-1:0]  base_nxt;
    logic [psr_pkg::BURST_W-1:0] cnt_r;
    logic [psr_pkg::BURST_W-1:0] cnt_nxt;
    logic [psr_pkg::BURST_W-1:0] cnt_inc;
    logic [psr_pkg::BURST_W-1:0] low_bits;

    // ==========================================================
    // Next address
    always_comb begin
        cnt_inc  = cnt_r + psr_pkg::BURST_ONE;
        low_bits = burst_linear ? base_r[1:0] + cnt_inc
                                : base_r[1:0] ^ cnt_inc;
        addr_out = load ? addr_in
                        : {base_r[psr_pkg::ADDR_W-1:2], low_bits};
        base_nxt = base_r;
        cnt_nxt  = cnt_r;
        if (step && load) begin
            base_nxt = addr_in;
            cnt_nxt  = psr_pkg::RST_BURST;
        end else if (step) begin
            cnt_nxt  = cnt_inc;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            base_r <= psr_pkg::RST_ADDR;
            cnt_r  <= psr_pkg::RST_BURST;
        end else begin
            base_r <= base_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

endmodule // psr_burst

// *** logic/psr_core.sv ***
// Pipelined burst static memory: input registers, two-stage command
// pipe, forwarded reads, registered data out with enable control.
// Assumes master pins are synchronous to core_clk; sleep is not.
`timescale 1ns/10ps

module psr_core (
    input  wire logic                           core_clk,
    input  wire logic                           rstn,
    input  wire logic                           clock_qualify_n,
    input  wire logic [psr_pkg::ADDR_W-1:0]     addr,
    input  wire logic                           chip_select_first_n,
    input  wire logic                           chip_select_second,
    input  wire logic                           chip_select_third_n,
    input  wire logic                           write_enable_n,
    input  wire logic [psr_pkg::LANE_N-1:0]     byte_lane_write_selects_n,
    input  wire logic                           advance_or_load,
    input  wire logic                           burst_linear,
    input  wire logic                           output_enable_n,
    input  wire logic                           sleep_request,
    input  wire logic [psr_pkg::DATA_W-1:0]     dq_in,
    output logic      [psr_pkg::DATA_W-1:0]     dq_out,
    output logic                                dq_oe_n
);

    // ==========================================================
    // Declarations
    logic                          en;
    logic                          cs_ok;
    logic                          load;
    logic                          new_vld;
    logic                          new_wr;
    logic [psr_pkg::ADDR_W-1:0]    eff_addr;
    logic [psr_pkg::DATA_W-1:0]    arr_data;
    logic [psr_pkg::DATA_W-1:0]    fwd_pend;
    logic [psr_pkg::DATA_W-1:0]    fwd_data;
    logic                          hit_pend;
    logic                          hit_s2;

    logic sleep_meta_r, sleep_meta_nxt;
    logic sleep_r,      sleep_nxt;
    logic last_vld_r,   last_vld_nxt;
    logic last_wr_r,    last_wr_nxt;
    logic s1_vld_r,     s1_vld_nxt;
    logic s1_wr_r,      s1_wr_nxt;
    logic s2_vld_r,     s2_vld_nxt;
    logic s2_wr_r,      s2_wr_nxt;
    logic wr_pend_r,    wr_pend_nxt;
    logic drive_r,      drive_nxt;
    logic [psr_pkg::ADDR_W-1:0] s1_addr_r, s1_addr_nxt;
    logic [psr_pkg::ADDR_W-1:0] s2_addr_r, s2_addr_nxt;
    logic [psr_pkg::ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [psr_pkg::LANE_N-1:0] s1_sel_r,  s1_sel_nxt;
    logic [psr_pkg::LANE_N-1:0] s2_sel_r,  s2_sel_nxt;
    logic [psr_pkg::LANE_N-1:0] wr_sel_r,  wr_sel_nxt;
    logic [psr_pkg::DATA_W-1:0] wr_data_r, wr_data_nxt;
    logic [psr_pkg::DATA_W-1:0] out_r,     out_nxt;

    // ==========================================================
    // Pin decode
    assign en    = ~clock_qualify_n;
    assign cs_ok = ~chip_select_first_n & chip_select_second
                 & ~chip_select_third_n;
    assign load  = ~advance_or_load;

    // Advance repeats the last loaded command kind and selection
    always_comb begin
        new_vld = (load ? cs_ok : last_vld_r) & ~sleep_r;
        new_wr  = load ? ~write_enable_n : last_wr_r;
    end

    // ==========================================================
    // Sleep input synchroniser
    always_comb begin
        sleep_meta_nxt = sleep_request;
        sleep_nxt      = sleep_meta_r;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sleep_meta_r <= 1'b0;
            sleep_r      <= 1'b0;
        end else begin
            sleep_meta_r <= sleep_meta_nxt;
            sleep_r      <= sleep_nxt;
        end
    end

    // ==========================================================
    // Burst address
    psr_burst u_burst (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .step         (en),
        .load         (load),
        .burst_linear (burst_linear),
        .addr_in      (addr),
        .addr_out     (eff_addr)
    );

    // ==========================================================
    // Command pipe: input registers then data-phase stage
    always_comb begin
        last_vld_nxt = last_vld_r;
        last_wr_nxt  = last_wr_r;
        s1_vld_nxt   = s1_vld_r;
        s1_wr_nxt    = s1_wr_r;
        s1_addr_nxt  = s1_addr_r;
        s1_sel_nxt   = s1_sel_r;
        s2_vld_nxt   = s2_vld_r;
        s2_wr_nxt    = s2_wr_r;
        s2_addr_nxt  = s2_addr_r;
        s2_sel_nxt   = s2_sel_r;
        if (en) begin
            if (load) begin
                last_vld_nxt = cs_ok;
                last_wr_nxt  = ~write_enable_n;
            end
            s1_vld_nxt  = new_vld;
            s1_wr_nxt   = new_wr;
            s1_addr_nxt = eff_addr;
            s1_sel_nxt  = ~byte_lane_write_selects_n;
            s2_vld_nxt  = s1_vld_r;
            s2_wr_nxt   = s1_wr_r;
            s2_addr_nxt = s1_addr_r;
            s2_sel_nxt  = s1_sel_r;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            last_vld_r <= 1'b0;
            last_wr_r  <= 1'b0;
            s1_vld_r   <= 1'b0;
            s1_wr_r    <= 1'b0;
            s1_addr_r  <= psr_pkg::RST_ADDR;
            s1_sel_r   <= psr_pkg::RST_SEL;
            s2_vld_r   <= 1'b0;
            s2_wr_r    <= 1'b0;
            s2_addr_r  <= psr_pkg::RST_ADDR;
            s2_sel_r   <= psr_pkg::RST_SEL;
        end else begin
            last_vld_r <= last_vld_nxt;
            last_wr_r  <= last_wr_nxt;
            s1_vld_r   <= s1_vld_nxt;
            s1_wr_r    <= s1_wr_nxt;
            s1_addr_r  <= s1_addr_nxt;
            s1_sel_r   <= s1_sel_nxt;
            s2_vld_r   <= s2_vld_nxt;
            s2_wr_r    <= s2_wr_nxt;
            s2_addr_r  <= s2_addr_nxt;
            s2_sel_r   <= s2_sel_nxt;
        end
    end

    // ==========================================================
    // Write capture; commit to array one edge later
    always_comb begin
        wr_pend_nxt = wr_pend_r;
        wr_addr_nxt = wr_addr_r;
        wr_sel_nxt  = wr_sel_r;
        wr_data_nxt = wr_data_r;
        if (en) begin
            wr_pend_nxt = s2_vld_r & s2_wr_r;
            if (s2_vld_r && s2_wr_r) begin
                wr_addr_nxt = s2_addr_r;
                wr_sel_nxt  = s2_sel_r;
                wr_data_nxt = dq_in;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= psr_pkg::RST_ADDR;
            wr_sel_r  <= psr_pkg::RST_SEL;
            wr_data_r <= psr_pkg::RST_DATA;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_sel_r  <= wr_sel_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // Rewriting a held pending word while stalled is harmless
    psr_array u_array (
        .core_clk (core_clk),
        .wr_en    (wr_pend_r),
        .wr_addr  (wr_addr_r),
        .wr_data  (wr_data_r),
        .wr_sel   (wr_sel_r),
        .rd_addr  (s1_addr_r),
        .rd_data  (arr_data)
    );

    // ==========================================================
    // Read forwarding: pending word, then write data on the pins
    assign hit_pend = wr_pend_r && (wr_addr_r == s1_addr_r);
    // Write data still on the pins wins over the pending word
    assign hit_s2   = s2_vld_r && s2_wr_r && (s2_addr_r == s1_addr_r);

    genvar g;
    generate
        for (g = 0; g < psr_pkg::LANE_N; g++) begin : g_fwd
            localparam int LO = g * psr_pkg::LANE_W;
            assign fwd_pend[LO +: psr_pkg::LANE_W] =
                (hit_pend && wr_sel_r[g]) ? wr_data_r[LO +: psr_pkg::LANE_W]
                                          : arr_data[LO +: psr_pkg::LANE_W];
            assign fwd_data[LO +: psr_pkg::LANE_W] =
                (hit_s2 && s2_sel_r[g]) ? dq_in[LO +: psr_pkg::LANE_W]
                                        : fwd_pend[LO +: psr_pkg::LANE_W];
        end
    endgenerate

    // ==========================================================
    // Output register and driver control
    always_comb begin
        out_nxt   = out_r;
        drive_nxt = drive_r;
        if (en) begin
            drive_nxt = s1_vld_r & ~s1_wr_r;
            if (s1_vld_r && !s1_wr_r) begin
                out_nxt = fwd_data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_r   <= psr_pkg::RST_DATA;
            drive_r <= 1'b0;
        end else begin
            out_r   <= out_nxt;
            drive_r <= drive_nxt;
        end
    end

    assign dq_out  = out_r;
    // Enable path is combinational so output enable needs no clock
    assign dq_oe_n = ~(drive_r & ~output_enable_n & ~sleep_r);

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence rd_issue;
        en && load && cs_ok && write_enable_n && !sleep_r;
    endsequence

    sequence wr_issue;
        en && load && cs_ok && !write_enable_n && !sleep_r;
    endsequence

    a_oe_async: assert property (
        output_enable_n |-> dq_oe_n)
        else $error("drivers on with output enable inactive");

    a_write_quiet: assert property (
        s2_vld_r && s2_wr_r |-> dq_oe_n)
        else $error("drivers on during write data cycle");

    a_stall_hold: assert property (
        !en |=> $stable(out_r) && $stable(s1_addr_r)
                && $stable(wr_pend_r) && $stable(drive_r))
        else $error("state moved while clock not qualified");

    a_read_launch: assert property (
        en && s1_vld_r && !s1_wr_r |=> drive_r
            && out_r == $past(fwd_data))
        else $error("read data not launched from register");

    a_deselect_drop: assert property (
        en && load && !cs_ok |=> !s1_vld_r)
        else $error("deselected cycle accepted");

    a_lane_capture: assert property (
        en && s2_vld_r && s2_wr_r |=> wr_pend_r
            && wr_sel_r == $past(s2_sel_r) && wr_data_r == $past(dq_in))
        else $error("write lanes not captured");

    a_back_to_back: assert property (
        rd_issue ##1 wr_issue |=> s2_vld_r && !s2_wr_r
            && s1_vld_r && s1_wr_r)
        else $error("mixed back-to-back command lost");

    a_read_latency: assert property (
        rd_issue ##1 en |=> drive_r)
        else $error("read data late");

    a_burst_linear: assert property (
        en && advance_or_load && burst_linear
            |=> s1_addr_r[1:0] == $past(s1_addr_r[1:0]) + 2'h1)
        else $error("linear burst step wrong");

    a_sleep_quiet: assert property (
        sleep_r |-> dq_oe_n && !new_vld)
        else $error("activity while asleep");

endmodule // psr_core

// *** bench/psr_master_model.sv ***
// Bus master model: drives write data into the memory two qualified
// edges after the write command, otherwise leaves the data bus alone.
// Assumes the bench raises cmd_write only for commands that will act.
`timescale 1ns/10ps

module psr_master_model (
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    input  wire logic                       clock_qualify_n,
    input  wire logic                       cmd_write,
    input  wire logic [psr_pkg::DATA_W-1:0] cmd_data,
    input  wire logic [psr_pkg::DATA_W-1:0] dq_out,
    input  wire logic                       dq_oe_n,
    output logic      [psr_pkg::DATA_W-1:0] dq_in,
    output logic                            clash
);
    logic                       wr0_r;
    logic                       wr1_r;
    logic [psr_pkg::DATA_W-1:0] wd0_r;
    logic [psr_pkg::DATA_W-1:0] wd1_r;
    logic [psr_pkg::DATA_W-1:0] noise_r;

    // Unqualified edges are ignored just as the memory ignores them
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr0_r <= 1'b0;
            wr1_r <= 1'b0;
        end else if (!clock_qualify_n) begin
            wr0_r <= cmd_write;
            wr1_r <= wr0_r;
            wd0_r <= cmd_data;
            wd1_r <= wd0_r;
        end
    end

    // Floating bus must not look like the last value
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            noise_r <= 36'h5_a5a5_a5a5;
        end else begin
            noise_r <= {noise_r[34:0], ~noise_r[35]};
        end
    end

    assign dq_in = wr1_r ? wd1_r : (!dq_oe_n ? dq_out : noise_r);
    assign clash = wr1_r & ~dq_oe_n;
endmodule // psr_master_model

// *** bench/psr_core_tb.sv ***
// Self-checking bench for the pipelined burst memory core.
// Assumes the master model resolves the shared data bus.
`timescale 1ns/10ps

module psr_core_tb;
    localparam int AW = psr_pkg::ADDR_W;
    localparam int DW = psr_pkg::DATA_W;

    logic          core_clk;
    logic          rstn;
    logic          clock_qualify_n;
    logic [AW-1:0] addr;
    logic          chip_select_first_n;
    logic          chip_select_second;
    logic          chip_select_third_n;
    logic          write_enable_n;
    logic [3:0]    byte_lane_write_selects_n;
    logic          advance_or_load;
    logic          burst_linear;
    logic          output_enable_n;
    logic          sleep_request;
    logic [DW-1:0] dq_in;
    logic [DW-1:0] dq_out;
    logic          dq_oe_n;
    logic          cmd_write;
    logic [DW-1:0] cmd_data;
    logic          clash;
    logic [1:0]    sel_bad;
    logic          refuse;
    int            p1_kind;
    logic [DW-1:0] p1_d;
    logic [DW-1:0] mem_m [logic [AW-1:0]];
    int            error_cnt;
    int            samples_checked;

    psr_core dut (.core_clk(core_clk), .rstn(rstn),
        .clock_qualify_n(clock_qualify_n), .addr(addr),
        .chip_select_first_n(chip_select_first_n),
        .chip_select_second(chip_select_second),
        .chip_select_third_n(chip_select_third_n),
        .write_enable_n(write_enable_n),
        .byte_lane_write_selects_n(byte_lane_write_selects_n),
        .advance_or_load(advance_or_load), .burst_linear(burst_linear),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

    psr_master_model master (.core_clk(core_clk), .rstn(rstn),
        .clock_qualify_n(clock_qualify_n), .cmd_write(cmd_write),
        .cmd_data(cmd_data), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dq_in(dq_in), .clash(clash));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One enabled cycle; kind 0 idle, 1 read, 2 write
    task automatic cyc(input int kind, input logic adv, input logic [AW-1:0] a,
                       input logic [3:0] bw_n, input logic [DW-1:0] wd);
        logic ok;
        ok = (kind != 0) && !refuse;
        chip_select_first_n = (sel_bad == 2'h1) || (kind == 0);
        chip_select_second = (sel_bad != 2'h2);
        chip_select_third_n = (sel_bad == 2'h3);
        write_enable_n = (kind != 2);
        advance_or_load = adv;
        addr = a;
        byte_lane_write_selects_n = bw_n;
        cmd_write = ok && (kind == 2);
        cmd_data = wd;
        if (cmd_write) begin
            if (!mem_m.exists(a)) mem_m[a] = 'x;
            for (int g = 0; g < 4; g++) begin
                if (!bw_n[g]) mem_m[a][9*g +: 9] = wd[9*g +: 9];
            end
        end
        @(posedge core_clk);
        #1;
        chk(clash, 1'b0);
        if (p1_kind == 1) begin
            chk(dq_out, p1_d);
            chk(dq_oe_n, output_enable_n);
        end else begin
            chk(dq_oe_n, 1'b1);
        end
        p1_kind = ok ? kind : 0;
        p1_d = (ok && kind == 1) ? mem_m[a] : 'x;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_mixed();
        cyc(2, 0, 21'h00_0010, 4'h0, 36'h1_1111_1111);
        cyc(1, 0, 21'h00_0010, 4'h0, '0);
        cyc(2, 0, 21'h00_0010, 4'ha, 36'h2_2222_2222);
        cyc(1, 0, 21'h00_0010, 4'h0, '0);
        cyc(2, 0, 21'h1f_ffff, 4'h0, 36'hf_0f0f_0f0f);
        cyc(1, 0, 21'h1f_ffff, 4'h0, '0);
        cyc(1, 0, 21'h00_0010, 4'h0, '0);
        cyc(0, 0, '0, 4'hf, '0);
        cyc(0, 0, '0, 4'hf, '0);
    endtask

    task automatic t_stall();
        logic [DW-1:0] hold_d;
        logic          hold_oe;
        cyc(2, 0, 21'h00_0040, 4'h0, 36'h1_2345_6789);
        cyc(1, 0, 21'h00_0040, 4'h0, '0);
        cyc(1, 0, 21'h00_0010, 4'h0, '0);
        // Second read differs, so a clock that is not held shows up
        hold_d = mem_m[21'h00_0040];
        hold_oe = 1'b0;
        clock_qualify_n = 1'b1;
        addr = 21'h00_0041;
        write_enable_n = 1'b0;
        repeat (3) begin
            @(posedge core_clk);
            #1;
            chk(dq_out, hold_d);
            chk(dq_oe_n, hold_oe);
        end
        clock_qualify_n = 1'b0;
        cyc(0, 0, '0, 4'hf, '0);
        cyc(0, 0, '0, 4'hf, '0);
    endtask

    // Each select alone blocks a write and a read
    task automatic t_desel();
        for (int k = 1; k < 4; k++) begin
            sel_bad = k[1:0];
            refuse = 1'b1;
            cyc(2, 0, 21'h00_0010, 4'h0, 36'hd_eadd_eadd);
            cyc(1, 0, 21'h00_0010, 4'h0, '0);
        end
        sel_bad = 2'h0;
        refuse = 1'b0;
        cyc(1, 0, 21'h00_0010, 4'h0, '0);
        cyc(0, 0, '0, 4'hf, '0);
    endtask

    // Bare edges repeat the same read, so p1 tracking stays valid
    task automatic t_oe();
        cyc(1, 0, 21'h00_0040, 4'h0, '0);
        cyc(1, 0, 21'h00_0040, 4'h0, '0);
        output_enable_n = 1'b1;
        #4;
        chk(dq_oe_n, 1'b1);
        @(posedge core_clk);
        #1;
        chk(dq_out, p1_d);
        output_enable_n = 1'b0;
        #4;
        chk(dq_oe_n, 1'b0);
        @(posedge core_clk);
        #1;
        output_enable_n = 1'b1;
        cyc(1, 0, 21'h00_0010, 4'h0, '0);
        cyc(0, 0, '0, 4'hf, '0);
        output_enable_n = 1'b0;
    endtask

    function automatic logic [AW-1:0] nb(input logic [AW-1:0] b, input int k,
                                         input logic lin);
        nb = b;
        nb[1:0] = lin ? b[1:0] + k[1:0] : b[1:0] ^ k[1:0];
    endfunction

    task automatic t_burst();
        logic [DW-1:0] wd;
        for (int i = 0; i < 4; i++) begin
            cyc(2, 0, 21'h00_0100 + AW'(i), 4'h0, 36'h0_0000_0ab0 + DW'(i));
        end
        for (int lin = 1; lin >= 0; lin--) begin
            burst_linear = lin[0];
            cyc(1, 0, 21'h00_0101, 4'h0, '0);
            for (int k = 1; k < 4; k++) begin
                cyc(1, 1, nb(21'h00_0101, k, lin[0]), 4'h0, '0);
            end
        end
        // Advancing writes repeat the loaded write kind
        burst_linear = 1'b1;
        cyc(2, 0, 21'h00_0200, 4'h0, 36'h0_0000_0cd0);
        for (int k = 1; k < 4; k++) begin
            wd = 36'h0_0000_0cd0 + DW'(k);
            cyc(2, 1, nb(21'h00_0200, k, 1'b1), 4'h0, wd);
        end
        for (int k = 0; k < 4; k++) begin
            cyc(1, 0, 21'h00_0200 + AW'(k), 4'h0, '0);
        end
        cyc(0, 0, '0, 4'hf, '0);
    endtask

    task automatic t_sleep();
        sleep_request = 1'b1;
        cyc(0, 0, '0, 4'hf, '0);
        cyc(0, 0, '0, 4'hf, '0);
        refuse = 1'b1;
        cyc(1, 0, 21'h00_0040, 4'h0, '0);
        cyc(0, 0, '0, 4'hf, '0);
        sleep_request = 1'b0;
        cyc(0, 0, '0, 4'hf, '0);
        cyc(0, 0, '0, 4'hf, '0);
        refuse = 1'b0;
        cyc(1, 0, 21'h00_0040, 4'h0, '0);
        cyc(0, 0, '0, 4'hf, '0);
    endtask

    // Hang guard
    initial begin
        #100_000;
        error_cnt++;
        $display("ERROR %0t: run did not complete", $time);
        final_report();
    end

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rstn = 1'b0;
        clock_qualify_n = 1'b0;
        addr = '0;
        chip_select_first_n = 1'b1;
        chip_select_second = 1'b1;
        chip_select_third_n = 1'b0;
        write_enable_n = 1'b1;
        byte_lane_write_selects_n = 4'hf;
        advance_or_load = 1'b0;
        burst_linear = 1'b1;
        output_enable_n = 1'b0;
        sleep_request = 1'b0;
        cmd_write = 1'b0;
        cmd_data = '0;
        sel_bad = 2'h0;
        refuse = 1'b0;
        p1_kind = 0;
        p1_d = '0;
        repeat (4) @(posedge core_clk);
        #1;
        chk(dq_out, psr_pkg::RST_DATA);
        chk(dq_oe_n, 1'b1);
        rstn = 1'b1;
        t_mixed();
        t_stall();
        t_desel();
        t_oe();
        t_burst();
        t_sleep();
        final_report();
    end
endmodule // psr_core_tb
